/* File: logic/cond_pkg.sv */
// Shared constants for the processor condition logic: device codes,
// bit positions of the status and control words, timing figures.
// Bits are numbered 18..35 from the left; index in an 18-bit vector
// is WORD_LAST minus the printed bit number.
package cond_pkg;

  localparam int unsigned WORD_W = 18;
  localparam int unsigned WORD_LAST = 35;
  localparam int unsigned DEV_W = 7;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned NCHAN = 7;

  // Device codes of the two addressed units
  localparam logic [DEV_W-1:0] DEV_PROC = 7'h00;
  localparam logic [DEV_W-1:0] DEV_PRIO = 7'h04;

  // Condition output to the priority interrupt system, low bits
  localparam int unsigned PI_CLR_PWR = WORD_LAST - 18;
  localparam int unsigned PI_CLR_PAR = WORD_LAST - 19;
  localparam int unsigned PI_DIS_PAR = WORD_LAST - 20;
  localparam int unsigned PI_ENA_PAR = WORD_LAST - 21;

  // Condition output to the processor device
  localparam int unsigned AP_RST_TMR = WORD_LAST - 18;
  localparam int unsigned AP_IO_CLR = WORD_LAST - 19;
  localparam int unsigned AP_DIS_TMR = WORD_LAST - 20;
  localparam int unsigned AP_ENA_TMR = WORD_LAST - 21;
  localparam int unsigned AP_DIS_ARS = WORD_LAST - 22;
  localparam int unsigned AP_ENA_ARS = WORD_LAST - 23;
  localparam int unsigned AP_DIS_CLK = WORD_LAST - 24;
  localparam int unsigned AP_ENA_CLK = WORD_LAST - 25;
  localparam int unsigned AP_CLR_CLK = WORD_LAST - 26;
  localparam int unsigned AP_CLR_IOPF = WORD_LAST - 28;
  localparam int unsigned AP_CLR_NXM = WORD_LAST - 29;
  localparam int unsigned AP_ERR_LO = WORD_LAST - 32;
  localparam int unsigned AP_CLK_LO = WORD_LAST - 35;

  // Status word of the priority interrupt system
  localparam int unsigned ST_PWR = WORD_LAST - 18;
  localparam int unsigned ST_PAR = WORD_LAST - 19;
  localparam int unsigned ST_PAR_EN = WORD_LAST - 20;
  localparam int unsigned ST_HELD_LO = WORD_LAST - 27;
  localparam int unsigned ST_SYS_ON = WORD_LAST - 28;
  localparam int unsigned ST_ON_LO = WORD_LAST - 35;

  // Status word of the processor device
  localparam int unsigned AS_TMR_FLG = WORD_LAST - 18;
  localparam int unsigned AS_TMR_EN = WORD_LAST - 21;
  localparam int unsigned AS_ARS_EN = WORD_LAST - 23;
  localparam int unsigned AS_CLK_EN = WORD_LAST - 25;
  localparam int unsigned AS_CLK_FLG = WORD_LAST - 26;
  localparam int unsigned AS_IOPF = WORD_LAST - 28;
  localparam int unsigned AS_NXM = WORD_LAST - 29;

  // Restart location, 70 octal, entered in kernel mode
  localparam logic [WORD_W-1:0] RESTART_LOC = 18'h00038;

  // Timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PWR_HOLD_US = 5000;
  localparam int unsigned TMR_PERIOD_MS = 1200;
  localparam int unsigned PWR_HOLD_CYC = PWR_HOLD_US * CLK_MHZ;
  localparam int unsigned TMR_PERIOD_CYC = TMR_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 28;

endpackage : cond_pkg

/* File: logic/hold_timer.sv */
// Cycle counter that pulses once each time its run input has stayed
// high for LIMIT cycles. Dropping run or raising restart starts over.
// Assumes core_clk and a synchronous active-high reset.
`timescale 1ns/1ps
module hold_timer #(
  parameter int unsigned CW = 28,
  parameter int unsigned LIMIT = 1000
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic restart,
  output logic expired
);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic at_end;
  logic expired_q;

  if (LIMIT < 1 || LIMIT > (2 ** CW))
  begin : g_chk
    $error("hold_timer LIMIT does not fit counter width");
  end

  assign at_end = (count_q == CW'(LIMIT - 1));
  // Wraps to zero at the end so a steady run pulses periodically
  assign count_d = (!run || restart || at_end) ? '0 : count_q + 1'b1;
  assign expired = expired_q;

  // Counter and registered expiry pulse
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      count_q <= '0;
      expired_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      expired_q <= run && !restart && at_end;
    end
  end

endmodule : hold_timer

/* File: logic/processor_condition_interrupts.sv */
// Processor condition logic: status words for condition input, flag and
// channel control by condition output, power-fail and timer restart.
// Assumes one instruction per valid cycle and that the interrupt system
// supplies its channel-on, held and system-on state as levels.
//
// Overview of operation
// - Status read shows turned-on channels one to seven in bits 29-35.
// - Status read shows channels holding an interrupt in bits 21-27.
// - Status bits 18-20 give power fail, parity error, parity enable.
// - Power failure flag requests an interrupt on the error channel.
// - Power failure flag held five milliseconds forces a processor clear.
// - Even-parity core read sets parity error flag, shown in bit 19.
// - Requests reach the interrupt system one cycle after the flag that causes them.
// - Two assignable channels: one for errors, one for the clock.
// - Processor conditions answer condition instructions with code 000.
// - Processor output loads channels from 30-35; ones in 18-26 and 28-29 act.
// - Auto restart only after running power drop with switch on.
// - No auto restart unless software handled the power failure flag.
// - Low supply or over temperature also set the power failure flag.
// - I/O page failure and missing memory set flags that request on the error channel.
// - Power and parity flags via interrupt system output; rest here.
// - Output bit 19 resets peripherals, leaves flags and interrupts.
// - Error channel from bits 30-32, clock channel from bits 33-35.
// - Unreset enabled timer sets flag, clears, restarts at location 70.
// - Clock flag sets at mains rate, requests only while bit 25 set.
`timescale 1ns/1ps
module processor_condition_interrupts
  import cond_pkg::*;
#(
  parameter int unsigned PWR_HOLD = cond_pkg::PWR_HOLD_CYC,
  parameter int unsigned TMR_PERIOD = cond_pkg::TMR_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic instr_output,
  input wire logic [cond_pkg::DEV_W-1:0] instr_dev,
  input wire logic [cond_pkg::WORD_W-1:0] instr_data,
  input wire logic [cond_pkg::NCHAN-1:0] chan_on,
  input wire logic [cond_pkg::NCHAN-1:0] chan_held,
  input wire logic sys_active,
  input wire logic mains_low,
  input wire logic supply_low,
  input wire logic over_temp,
  input wire logic power_switch_on,
  input wire logic proc_running,
  input wire logic parity_even,
  input wire logic line_tick,
  input wire logic io_page_fail,
  input wire logic nxm_fail,
  output logic [cond_pkg::WORD_W-1:0] status_data,
  output logic status_valid,
  output logic [cond_pkg::NCHAN-1:0] err_chan_req,
  output logic [cond_pkg::NCHAN-1:0] clk_chan_req,
  output logic io_reset,
  output logic proc_clear,
  output logic restart,
  output logic [cond_pkg::WORD_W-1:0] restart_addr
);
  import cond_pkg::*;

  if (PWR_HOLD < 1 || TMR_PERIOD < 1 || TMR_PERIOD >= (2 ** CNT_W) ||
      PWR_HOLD >= (2 ** CNT_W))
  begin : g_chk
    $error("timing counts out of range for counter width");
  end

  // Channel number to request line; channel 0 means none assigned
  function automatic logic [NCHAN-1:0] chan_line(
    input logic [CHAN_W-1:0] ch
  );
    logic [NCHAN-1:0] line;
    line = '0;
    if (ch != '0)
    begin
      line[ch - 1'b1] = 1'b1;
    end
    return line;
  endfunction : chan_line

  // Channel one sits leftmost in the word, so the order is reversed
  function automatic logic [NCHAN-1:0] chan_field(
    input logic [NCHAN-1:0] ch
  );
    logic [NCHAN-1:0] f;
    f = '0;
    for (int i = 0; i < NCHAN; i++)
    begin
      f[NCHAN-1-i] = ch[i];
    end
    return f;
  endfunction : chan_field

  typedef enum logic [1:0] {PWR_IDLE, PWR_HOLDING, PWR_ARMED}
    pwr_state_e;

  logic pwr_flag_q, pwr_flag_d;
  logic par_flag_q, par_flag_d;
  logic par_en_q, par_en_d;
  logic clk_flag_q, clk_flag_d;
  logic clk_en_q, clk_en_d;
  logic tmr_flag_q, tmr_flag_d;
  logic tmr_en_q, tmr_en_d;
  logic ars_en_q, ars_en_d;
  logic iopf_q, iopf_d;
  logic nxm_q, nxm_d;
  logic handled_q, handled_d;
  logic ran_q, ran_d;
  logic [CHAN_W-1:0] err_ch_q;
  logic [CHAN_W-1:0] clk_ch_q;
  pwr_state_e pwr_q, pwr_d;
  logic [WORD_W-1:0] status_q;
  logic status_valid_q;
  logic [NCHAN-1:0] err_req_q;
  logic [NCHAN-1:0] clk_req_q;
  logic io_reset_q;
  logic proc_clear_q;
  logic restart_q;
  logic [WORD_W-1:0] restart_addr_q;

  // Instruction decode
  logic wr_prio, wr_proc, rd_prio, rd_proc;
  logic fault_any, pwr_set, pwr_clr, pwr_hold_run, pwr_expired;
  logic tmr_expired, tmr_kick, restart_go;
  logic [WORD_W-1:0] prio_word, proc_word;
  logic [NCHAN-1:0] err_req_d, clk_req_d;

  assign wr_prio = instr_valid && instr_output && (instr_dev == DEV_PRIO);
  assign wr_proc = instr_valid && instr_output &&
                   (instr_dev == DEV_PROC);
  assign rd_prio = instr_valid && !instr_output && (instr_dev == DEV_PRIO);
  assign rd_proc = instr_valid && !instr_output &&
                   (instr_dev == DEV_PROC);

  // Power failure sources and flag; any active fault source beats a clear
  assign fault_any = mains_low || supply_low || over_temp;
  assign pwr_set = fault_any && !pwr_flag_q;
  assign pwr_clr = wr_prio && instr_data[PI_CLR_PWR];
  assign pwr_flag_d = fault_any || (pwr_flag_q && !pwr_clr);

  // Parity error and its enable, driven from the interrupt system output
  assign par_flag_d = parity_even ||
                      (par_flag_q && !(wr_prio && instr_data[PI_CLR_PAR]));
  assign par_en_d = (wr_prio && instr_data[PI_ENA_PAR]) ? 1'b1 :
                    (wr_prio && instr_data[PI_DIS_PAR]) ? 1'b0 :
                    par_en_q;

  // Processor device flags; each 1 acts, each 0 leaves the state alone
  assign clk_flag_d = line_tick ||
                      (clk_flag_q && !(wr_proc && instr_data[AP_CLR_CLK]));
  assign clk_en_d = (wr_proc && instr_data[AP_ENA_CLK]) ? 1'b1 :
                    (wr_proc && instr_data[AP_DIS_CLK]) ? 1'b0 :
                    clk_en_q;
  assign tmr_en_d = (wr_proc && instr_data[AP_ENA_TMR]) ? 1'b1 :
                    (wr_proc && instr_data[AP_DIS_TMR]) ? 1'b0 :
                    tmr_en_q;
  assign ars_en_d = (wr_proc && instr_data[AP_ENA_ARS]) ? 1'b1 :
                    (wr_proc && instr_data[AP_DIS_ARS]) ? 1'b0 :
                    ars_en_q;
  assign iopf_d = io_page_fail ||
                  (iopf_q && !(wr_proc && instr_data[AP_CLR_IOPF]));
  assign nxm_d = nxm_fail ||
                 (nxm_q && !(wr_proc && instr_data[AP_CLR_NXM]));

  // Watchdog: a reset through bit 18 restarts the count and drops the flag
  assign tmr_kick = wr_proc && instr_data[AP_RST_TMR];
  assign tmr_flag_d = tmr_expired || (tmr_flag_q && !tmr_kick);

  // Power-down sequence. The hold count keeps running after software has
  // answered the flag while the fault persists, so the clear still comes.
  assign pwr_hold_run = (pwr_q == PWR_HOLDING) &&
                        (pwr_flag_q || (handled_q && fault_any));
  assign handled_d = (pwr_q == PWR_IDLE) ? 1'b0 :
                     (handled_q || pwr_clr);
  assign ran_d = pwr_set ? proc_running : ran_q;
  assign restart_go = (pwr_q == PWR_ARMED) && !fault_any &&
                      power_switch_on;

  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_IDLE:
        if (pwr_set)
        begin
          pwr_d = PWR_HOLDING;
        end
      PWR_HOLDING:
        if (pwr_expired)
        begin
          // Restart only if running at the drop and software answered
          pwr_d = (ran_q && ars_en_q && (handled_q || pwr_clr)) ?
                  PWR_ARMED : PWR_IDLE;
        end
        else if (!pwr_hold_run)
        begin
          pwr_d = PWR_IDLE;
        end
      PWR_ARMED:
        if (restart_go)
        begin
          pwr_d = PWR_IDLE;
        end
      default:
        pwr_d = PWR_IDLE;
    endcase
  end

  // Requests are registered levels, so the grant logic sees them one cycle after the flags
  assign err_req_d = (pwr_flag_q || (par_flag_q && par_en_q) ||
                      iopf_q || nxm_q) ?
                     chan_line(err_ch_q) : '0;
  assign clk_req_d = (clk_flag_q && clk_en_q) ?
                     chan_line(clk_ch_q) : '0;

  // Status words are pure views of live state
  always_comb
  begin
    prio_word = '0;
    prio_word[ST_PWR] = pwr_flag_q;
    prio_word[ST_PAR] = par_flag_q;
    prio_word[ST_PAR_EN] = par_en_q;
    prio_word[ST_HELD_LO +: NCHAN] = chan_field(chan_held);
    prio_word[ST_SYS_ON] = sys_active;
    prio_word[ST_ON_LO +: NCHAN] = chan_field(chan_on);
  end

  always_comb
  begin
    proc_word = '0;
    proc_word[AS_TMR_FLG] = tmr_flag_q;
    proc_word[AS_TMR_EN] = tmr_en_q;
    proc_word[AS_ARS_EN] = ars_en_q;
    proc_word[AS_CLK_EN] = clk_en_q;
    proc_word[AS_CLK_FLG] = clk_flag_q;
    proc_word[AS_IOPF] = iopf_q;
    proc_word[AS_NXM] = nxm_q;
    proc_word[AP_ERR_LO +: CHAN_W] = err_ch_q;
    proc_word[AP_CLK_LO +: CHAN_W] = clk_ch_q;
  end

  hold_timer #(
    .CW(CNT_W),
    .LIMIT(PWR_HOLD)
  ) u_pwr_hold (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(pwr_hold_run),
    .restart(1'b0),
    .expired(pwr_expired)
  );

  hold_timer #(
    .CW(CNT_W),
    .LIMIT(TMR_PERIOD)
  ) u_watchdog (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(tmr_en_q),
    .restart(tmr_kick),
    .expired(tmr_expired)
  );

  // Condition flags and enables
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pwr_flag_q <= 1'b0;
      par_flag_q <= 1'b0;
      par_en_q <= 1'b0;
      clk_flag_q <= 1'b0;
      clk_en_q <= 1'b0;
      tmr_flag_q <= 1'b0;
      tmr_en_q <= 1'b0;
      ars_en_q <= 1'b0;
      iopf_q <= 1'b0;
      nxm_q <= 1'b0;
    end
    else
    begin
      pwr_flag_q <= pwr_flag_d;
      par_flag_q <= par_flag_d;
      par_en_q <= par_en_d;
      clk_flag_q <= clk_flag_d;
      clk_en_q <= clk_en_d;
      tmr_flag_q <= tmr_flag_d;
      tmr_en_q <= tmr_en_d;
      ars_en_q <= ars_en_d;
      iopf_q <= iopf_d;
      nxm_q <= nxm_d;
    end
  end

  // Channel assignments load whole on every processor output
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      err_ch_q <= '0;
      clk_ch_q <= '0;
    end
    else if (wr_proc)
    begin
      err_ch_q <= instr_data[AP_ERR_LO +: CHAN_W];
      clk_ch_q <= instr_data[AP_CLK_LO +: CHAN_W];
    end
  end

  // Power-down sequencer state
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pwr_q <= PWR_IDLE;
      handled_q <= 1'b0;
      ran_q <= 1'b0;
    end
    else
    begin
      pwr_q <= pwr_d;
      handled_q <= handled_d;
      ran_q <= ran_d;
    end
  end

  // Registered outputs; a status read has no side effect on any flag
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
      status_valid_q <= 1'b0;
      err_req_q <= '0;
      clk_req_q <= '0;
      io_reset_q <= 1'b0;
      proc_clear_q <= 1'b0;
      restart_q <= 1'b0;
      restart_addr_q <= '0;
    end
    else
    begin
      status_q <= rd_prio ? prio_word :
                  rd_proc ? proc_word : status_q;
      status_valid_q <= rd_prio || rd_proc;
      err_req_q <= err_req_d;
      clk_req_q <= clk_req_d;
      io_reset_q <= (wr_proc && instr_data[AP_IO_CLR]) ||
                    tmr_expired;
      proc_clear_q <= pwr_expired || tmr_expired;
      restart_q <= restart_go || tmr_expired;
      restart_addr_q <= RESTART_LOC;
    end
  end

  assign status_data = status_q;
  assign status_valid = status_valid_q;
  assign err_chan_req = err_req_q;
  assign clk_chan_req = clk_req_q;
  assign io_reset = io_reset_q;
  assign proc_clear = proc_clear_q;
  assign restart = restart_q;
  assign restart_addr = restart_addr_q;

endmodule : processor_condition_interrupts

/* File: verif/cond_properties.sv */
// Port checker for the processor condition block.
// Assumes it is bound to the design top; one clock, sync reset.
`timescale 1ns/1ps
module cond_properties
  import cond_pkg::*;
#(
  parameter int unsigned PWR_HOLD = 20,
  parameter int unsigned TMR_PERIOD = 50
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic instr_output,
  input wire logic [cond_pkg::DEV_W-1:0] instr_dev,
  input wire logic [cond_pkg::WORD_W-1:0] instr_data,
  input wire logic [cond_pkg::NCHAN-1:0] chan_on,
  input wire logic [cond_pkg::NCHAN-1:0] chan_held,
  input wire logic sys_active,
  input wire logic [cond_pkg::WORD_W-1:0] status_data,
  input wire logic status_valid,
  input wire logic [cond_pkg::NCHAN-1:0] err_chan_req,
  input wire logic [cond_pkg::NCHAN-1:0] clk_chan_req,
  input wire logic io_reset,
  input wire logic proc_clear,
  input wire logic restart,
  input wire logic [cond_pkg::WORD_W-1:0] restart_addr
);
  // Channel one sits at the top of each status field, so reverse
  wire [NCHAN-1:0] on_rev = {<<{chan_on}};
  wire [NCHAN-1:0] held_rev = {<<{chan_held}};
  wire known_dev = (instr_dev == DEV_PROC) || (instr_dev == DEV_PRIO);
  wire io_cmd = instr_valid && instr_output && (instr_dev == DEV_PROC)
    && instr_data[AP_IO_CLR];

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Instruction steps that start the checked behaviours
  sequence s_prio_read;
    instr_valid && !instr_output && (instr_dev == DEV_PRIO);
  endsequence
  sequence s_io_write;
    io_cmd;
  endsequence

  a_read_on: assert property (
    s_prio_read |=> status_valid && status_data[6:0] == $past(on_rev))
    else $error("channel-on field wrong");
  a_read_held: assert property (
    s_prio_read |=> status_data[14:8] == $past(held_rev))
    else $error("held field wrong");
  a_read_sys: assert property (
    s_prio_read |=> status_data[ST_SYS_ON] == $past(sys_active))
    else $error("system-on bit wrong");
  a_no_answer: assert property (
    instr_valid && (instr_output || !known_dev) |=> !status_valid)
    else $error("status answered a non-read");
  a_io_reset: assert property (
    s_io_write |=> io_reset)
    else $error("io reset missing");
  a_io_cause: assert property (
    io_reset && !proc_clear |-> $past(io_cmd))
    else $error("io reset without command");
  a_err_onehot: assert property (
    $onehot0(err_chan_req))
    else $error("error request on several channels");
  a_clk_onehot: assert property (
    $onehot0(clk_chan_req))
    else $error("clock request on several channels");
  a_restart_loc: assert property (
    restart |-> restart_addr == RESTART_LOC ##1 !restart)
    else $error("restart location or width wrong");
  a_status_hold: assert property (
    !status_valid && !$past(sys_rst) |-> $stable(status_data))
    else $error("status word moved without a read");
endmodule : cond_properties

bind processor_condition_interrupts cond_properties #(
  .PWR_HOLD(PWR_HOLD), .TMR_PERIOD(TMR_PERIOD)
) cond_properties_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .instr_output(instr_output), .instr_dev(instr_dev),
  .instr_data(instr_data), .chan_on(chan_on), .chan_held(chan_held),
  .sys_active(sys_active), .status_data(status_data),
  .status_valid(status_valid), .err_chan_req(err_chan_req),
  .clk_chan_req(clk_chan_req), .io_reset(io_reset),
  .proc_clear(proc_clear), .restart(restart), .restart_addr(restart_addr)
);

/* File: verif/tb_processor_condition_interrupts.sv */
// Self-checking bench for the processor condition block.
// Assumes hold and watchdog counts shortened to PH and TP cycles.
`timescale 1ns/1ps
module tb_processor_condition_interrupts;
  import cond_pkg::*;
  localparam int unsigned PH = 20;
  localparam int unsigned TP = 50;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic instr_valid = 1'h0;
  logic instr_output = 1'h0;
  logic [DEV_W-1:0] instr_dev = 7'h00;
  logic [WORD_W-1:0] instr_data = 18'h00000;
  logic [NCHAN-1:0] chan_on = 7'h00;
  logic [NCHAN-1:0] chan_held = 7'h00;
  logic sys_active = 1'h0;
  logic mains_low = 1'h0;
  logic supply_low = 1'h0;
  logic over_temp = 1'h0;
  logic power_switch_on = 1'h0;
  logic proc_running = 1'h0;
  logic parity_even = 1'h0;
  logic line_tick = 1'h0;
  logic io_page_fail = 1'h0;
  logic nxm_fail = 1'h0;
  logic [WORD_W-1:0] status_data;
  logic status_valid;
  logic [NCHAN-1:0] err_chan_req;
  logic [NCHAN-1:0] clk_chan_req;
  logic io_reset;
  logic proc_clear;
  logic restart;
  logic [WORD_W-1:0] restart_addr;
  int num_errors = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  // Page-fail and missing-memory inputs are pulsed in the parity scenario
  processor_condition_interrupts #(.PWR_HOLD(PH), .TMR_PERIOD(TP))
  processor_condition_interrupts_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_output(instr_output), .instr_dev(instr_dev),
    .instr_data(instr_data), .chan_on(chan_on), .chan_held(chan_held),
    .sys_active(sys_active), .mains_low(mains_low),
    .supply_low(supply_low), .over_temp(over_temp),
    .power_switch_on(power_switch_on), .proc_running(proc_running),
    .parity_even(parity_even), .line_tick(line_tick),
    .io_page_fail(io_page_fail), .nxm_fail(nxm_fail),
    .status_data(status_data),
    .status_valid(status_valid), .err_chan_req(err_chan_req),
    .clk_chan_req(clk_chan_req), .io_reset(io_reset),
    .proc_clear(proc_clear), .restart(restart),
    .restart_addr(restart_addr)
  );

  // Clock and a free cycle count for measuring spans
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc_cnt <= cyc_cnt + 1;

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [WORD_W-1:0] seen,
    input logic [WORD_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic do_reset();
    sys_rst = 1'h1;
    {mains_low, supply_low, over_temp} = 3'h0;
    cyc(8);
    sys_rst = 1'h0;
  endtask : do_reset

  task automatic put(input logic wr, input logic [DEV_W-1:0] dev,
    input logic [WORD_W-1:0] d);
    instr_valid = 1'h1;
    instr_output = wr;
    instr_dev = dev;
    instr_data = d;
    cyc(1);
    instr_valid = 1'h0;
  endtask : put

  // Returns when requests already reflect the written state
  task automatic wr(input logic [DEV_W-1:0] dev, input logic [WORD_W-1:0] d);
    put(1'h1, dev, d);
    cyc(1);
  endtask : wr

  task automatic rd(input logic [DEV_W-1:0] dev,
    output logic [WORD_W-1:0] w, output logic v);
    put(1'h0, dev, 18'h00000);
    w = status_data;
    v = status_valid;
    cyc(1);
  endtask : rd

  task automatic t_status();
    logic [WORD_W-1:0] w;
    logic v;
    do_reset();
    chan_on = 7'h53;
    chan_held = 7'h05;
    sys_active = 1'h1;
    cyc(1);
    rd(DEV_PRIO, w, v);
    chk("prio_valid", 18'(v), 18'h00001);
    chk("prio_word", w, {3'h0, 7'h50, 1'h1, 7'h65});
    rd(7'h05, w, v);
    chk("other_dev", 18'(v), 18'h00000);
  endtask : t_status

  task automatic t_parity();
    logic [WORD_W-1:0] w;
    logic v;
    do_reset();
    wr(DEV_PROC, 18'h00018);
    parity_even = 1'h1;
    cyc(1);
    parity_even = 1'h0;
    cyc(1);
    chk("par_masked", 18'(err_chan_req), 18'h00000);
    wr(DEV_PRIO, 18'h04000);
    chk("par_req", 18'(err_chan_req), 18'h00004);
    rd(DEV_PRIO, w, v);
    chk("par_flags", w & 18'h38000, 18'h18000);
    chk("read_keeps", 18'(err_chan_req), 18'h00004);
    wr(DEV_PRIO, 18'h08000);
    chk("par_disabled", 18'(err_chan_req), 18'h00000);
    // Re-enable in the same word so only the clear can drop the request
    wr(DEV_PRIO, 18'h14000);
    chk("par_clear", 18'(err_chan_req), 18'h00000);
    // Page-fail and missing-memory flags share the error channel
    {io_page_fail, nxm_fail} = 2'h3;
    cyc(1);
    {io_page_fail, nxm_fail} = 2'h0;
    cyc(1);
    chk("fail_req", 18'(err_chan_req), 18'h00004);
    wr(DEV_PROC, 18'h00098);
    chk("nxm_holds", 18'(err_chan_req), 18'h00004);
    wr(DEV_PROC, 18'h00058);
    chk("fail_clear", 18'(err_chan_req), 18'h00000);
  endtask : t_parity

  task automatic t_clock();
    logic [WORD_W-1:0] w;
    logic v;
    do_reset();
    wr(DEV_PROC, 18'h00005);
    line_tick = 1'h1;
    cyc(1);
    line_tick = 1'h0;
    cyc(1);
    chk("clk_masked", 18'(clk_chan_req), 18'h00000);
    wr(DEV_PROC, 18'h00405);
    chk("clk_req", 18'(clk_chan_req), 18'h00010);
    rd(DEV_PROC, w, v);
    chk("proc_word", w, 18'h00605);
    put(1'h1, DEV_PROC, 18'h10005);
    chk("io_pulse", 18'({io_reset, proc_clear}), 18'h00002);
    cyc(1);
    chk("clk_kept", 18'(clk_chan_req), 18'h00010);
    wr(DEV_PROC, 18'h00805);
    chk("clk_disabled", 18'(clk_chan_req), 18'h00000);
    // Enable with the clear so only the clear can drop the request
    wr(DEV_PROC, 18'h00605);
    chk("clk_clear", 18'(clk_chan_req), 18'h00000);
  endtask : t_clock

  // Fault f: 2 mains, 1 supply, 0 temperature; clr is the software reply
  task automatic pwr_run(input int f, input logic clr, input logic run,
    input logic exp);
    int t0;
    int i;
    logic seen;
    seen = 1'h0;
    do_reset();
    power_switch_on = 1'h1;
    proc_running = run;
    wr(DEV_PROC, 18'h01008);
    t0 = cyc_cnt;
    {mains_low, supply_low, over_temp} = 3'(1 << f);
    cyc(2);
    chk("pwr_req", 18'(err_chan_req), 18'h00001);
    if (clr)
      wr(DEV_PRIO, 18'h20000);
    for (i = 0; i < 4 * PH && proc_clear !== 1'h1; i++)
      cyc(1);
    chk("hold", 18'(cyc_cnt - t0 inside {[PH:PH + 4]}), 18'h1);
    // Restart before power returns counts as a wrong restart
    for (i = 0; i < 12; i++)
    begin
      if (i == 3)
        {mains_low, supply_low, over_temp} = 3'h0;
      if (i == 8)
        power_switch_on = 1'h0;
      if (i == 9)
        power_switch_on = 1'h1;
      if (restart === 1'h1)
        seen = (i < 4) ? ~exp : exp;
      cyc(1);
    end
    chk("restart", 18'(seen), 18'(exp));
  endtask : pwr_run

  task automatic t_watchdog();
    logic [WORD_W-1:0] w;
    logic v;
    int t0;
    int i;
    logic seen;
    seen = 1'h0;
    do_reset();
    wr(DEV_PROC, 18'h04000);
    // Kick well inside the period; no clear may occur meanwhile
    for (i = 0; i < 80; i++)
    begin
      if (i % 20 == 19)
        put(1'h1, DEV_PROC, 18'h20000);
      seen = seen | (proc_clear === 1'h1);
      cyc(1);
    end
    chk("kicked", 18'(seen), 18'h00000);
    t0 = cyc_cnt;
    for (i = 0; i < 3 * TP && restart !== 1'h1; i++)
      cyc(1);
    chk("wd_fire", 18'({io_reset, proc_clear, restart}), 18'h7);
    chk("wd_span", 18'(cyc_cnt - t0 inside {[TP - 2:TP + 3]}), 18'h1);
    rd(DEV_PROC, w, v);
    chk("wd_flag", w & 18'h24000, 18'h24000);
    // A disabled timer must stay quiet well past its period
    wr(DEV_PROC, 18'h08000);
    seen = 1'h0;
    for (i = 0; i < 2 * TP; i++)
    begin
      seen = seen | (restart === 1'h1);
      cyc(1);
    end
    chk("wd_off", 18'(seen), 18'h00000);
  endtask : t_watchdog

  // Main sequence
  initial
  begin
    t_status();
    t_parity();
    t_clock();
    pwr_run(0, 1'h1, 1'h1, 1'h1);
    pwr_run(2, 1'h0, 1'h1, 1'h0);
    pwr_run(1, 1'h1, 1'h0, 1'h0);
    t_watchdog();
    end_sim();
  end

  // Watchdog: the whole run needs well under this span
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : tb_processor_condition_interrupts
